// ==== rtl/pcrb_top.sv ====
// pcrb_top: paged configuration register bank with run-time change gating
// assumes: register port driven by the control interface logic on sys_clk_i;
//          monitor samples, live events and change requests on the same clock
//
// Functional notes
// - 8-bit page select picks page 0..255
// - page select resets to page zero
// - bit1 set blocks volume change while ADC on
// - bit0 set applies filter coefficients on the fly
// - diagnostic configs a, b, c reset to 0xba, 0x4b, 0x48; diag data config resets to 0x00
// - monitor low bytes reset to codes, high zero
`timescale 1ns/100ps
`default_nettype none
module pcrb_top
   import pcrb_pkg::*;
(
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_b_i,
   // register port
   input  wire logic [pcrb_pkg::PCRB_AW-1:0] reg_addr_i,
   input  wire logic [pcrb_pkg::PCRB_DW-1:0] reg_wdata_i,
   input  wire logic                        reg_wr_i,
   input  wire logic                        reg_rd_i,
   output logic [pcrb_pkg::PCRB_DW-1:0]      reg_rdata_o,
   output logic                             reg_rvalid_o,
   // page and processing control
   output logic [pcrb_pkg::PCRB_DW-1:0]      page_o,
   output logic                             block_runtime_volume_change_o,
   output logic                             allow_runtime_filter_change_o,
   // diagnostic configuration
   output logic [pcrb_pkg::PCRB_DW-1:0]      diag_cfg_a_o,
   output logic [pcrb_pkg::PCRB_DW-1:0]      diag_cfg_b_o,
   output logic [pcrb_pkg::PCRB_DW-1:0]      diag_cfg_c_o,
   output logic [pcrb_pkg::PCRB_DW-1:0]      diag_data_cfg_o,
   // datapath state
   input  wire logic                        adc_powered_i,
   input  wire logic [pcrb_pkg::PCRB_DW-1:0] live_event_i,
   input  wire logic                        mon_valid_i,
   input  wire logic [pcrb_pkg::PCRB_MON_IW-1:0] mon_chan_i,
   input  wire logic [15:0]                 mon_data_i,
   // digital volume change
   input  wire logic                        vol_req_i,
   input  wire logic [pcrb_pkg::PCRB_DW-1:0] vol_value_i,
   output logic [pcrb_pkg::PCRB_DW-1:0]      digital_volume_o,
   output logic                             vol_pending_o,
   // filter coefficient change
   input  wire logic                        coef_req_i,
   input  wire logic [pcrb_pkg::PCRB_COEF_AW-1:0] coef_addr_i,
   input  wire logic [pcrb_pkg::PCRB_DW-1:0] coef_data_i,
   output logic                             coef_wr_o,
   output logic [pcrb_pkg::PCRB_COEF_AW-1:0] coef_addr_o,
   output logic [pcrb_pkg::PCRB_DW-1:0]      coef_data_o,
   output logic                             coef_pending_o
);
   import pcrb_pkg::*;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   pcrb_byte_t page_reg;
   pcrb_byte_t proc_reg;
   pcrb_byte_t live3_reg;
   pcrb_byte_t diaga_reg;
   pcrb_byte_t diagb_reg;
   pcrb_byte_t diagc_reg;
   pcrb_byte_t ddata_reg;
   pcrb_byte_t rdata_reg;
   logic       rvalid_reg;

   pcrb_byte_t vol_reg;
   pcrb_byte_t vol_hold_reg;
   logic       vol_pend_reg;

   logic                    coef_wr_reg;
   logic [PCRB_COEF_AW-1:0] coef_addr_reg;
   pcrb_byte_t              coef_data_reg;
   logic [PCRB_COEF_AW-1:0] coef_addr_hold_reg;
   pcrb_byte_t              coef_data_hold_reg;
   logic                    coef_pend_reg;

   logic       on_page0;
   logic       sel_page;
   logic       wr_hit;
   logic       vol_blocked;
   logic       filt_open;
   logic       mon_hit;
   logic       mon_hi;
   logic [PCRB_MON_IW-1:0] mon_idx;
   pcrb_byte_t rd_next;

   pcrb_mon_if mon_bus ();

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   // page select answers on every page, the rest only on page 0
   assign sel_page = (reg_addr_i == PCRB_OFS_PAGE);
   assign on_page0 = (page_reg == 8'h00);
   assign wr_hit   = reg_wr_i && on_page0 && !sel_page;

   always_comb begin
      mon_hit = 1'b0;
      mon_hi  = 1'b0;
      mon_idx = '0;
      for (int i = 0; i < PCRB_MON_N; i++) begin
         if (reg_addr_i == PCRB_MON_HI_OFS[i]) begin
            mon_hit = 1'b1;
            mon_hi  = 1'b1;
            mon_idx = PCRB_MON_IW'(i);
         end
         if (reg_addr_i == PCRB_MON_LO_OFS[i]) begin
            mon_hit = 1'b1;
            mon_hi  = 1'b0;
            mon_idx = PCRB_MON_IW'(i);
         end
      end
   end

   // ---------------------------------------------------------------
   // monitor bank
   // ---------------------------------------------------------------
   assign mon_bus.smp_valid = mon_valid_i;
   assign mon_bus.smp_idx   = mon_chan_i;
   assign mon_bus.smp_data  = mon_data_i;
   assign mon_bus.rd_idx    = mon_idx;
   assign mon_bus.rd_hi     = mon_hi;

   pcrb_mon_bank u_mon_bank (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .mon       (mon_bus.bank)
   );

   // ---------------------------------------------------------------
   // page select
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         page_reg <= PCRB_RST_PAGE;
      end else if (reg_wr_i && sel_page) begin
         page_reg <= reg_wdata_i;
      end
   end

   // ---------------------------------------------------------------
   // processing control
   // ---------------------------------------------------------------
   // bit 4 never stores a one; other high bits hold what the host wrote
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         proc_reg <= PCRB_RST_PROC;
      end else if (wr_hit && reg_addr_i == PCRB_OFS_PROC) begin
         proc_reg <= reg_wdata_i & PCRB_PROC_RW_MASK;
      end
   end

   assign vol_blocked = proc_reg[PCRB_BIT_VOL] && adc_powered_i;
   assign filt_open   = proc_reg[PCRB_BIT_FILT] || !adc_powered_i;

   // ---------------------------------------------------------------
   // diagnostic configuration
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         diaga_reg <= PCRB_RST_DIAGA;
         diagb_reg <= PCRB_RST_DIAGB;
         diagc_reg <= PCRB_RST_DIAGC;
         ddata_reg <= PCRB_RST_DDATA;
      end else if (wr_hit) begin
         if (reg_addr_i == PCRB_OFS_DIAGA) begin
            diaga_reg <= reg_wdata_i;
         end
         if (reg_addr_i == PCRB_OFS_DIAGB) begin
            diagb_reg <= reg_wdata_i;
         end
         if (reg_addr_i == PCRB_OFS_DIAGC) begin
            diagc_reg <= reg_wdata_i;
         end
         if (reg_addr_i == PCRB_OFS_DDATA) begin
            ddata_reg <= reg_wdata_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // live event readback
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         live3_reg <= PCRB_RST_LIVE3;
      end else begin
         live3_reg <= live_event_i;
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   always_comb begin
      rd_next = 8'h00;
      if (sel_page) begin
         rd_next = page_reg;
      end else if (on_page0) begin
         if (mon_hit) begin
            rd_next = mon_bus.rd_data;
         end else begin
            case (reg_addr_i)
               PCRB_OFS_PROC: rd_next = proc_reg;
               PCRB_OFS_LIVE3: rd_next = live3_reg;
               PCRB_OFS_DIAGA: rd_next = diaga_reg;
               PCRB_OFS_DIAGB: rd_next = diagb_reg;
               PCRB_OFS_DIAGC: rd_next = diagc_reg;
               PCRB_OFS_DDATA: rd_next = ddata_reg;
               default: rd_next = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_reg <= rd_next;
         end
      end
   end

   // ---------------------------------------------------------------
   // digital volume change
   // ---------------------------------------------------------------
   // a blocked request is held and applied once the block lifts
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         vol_reg      <= PCRB_RST_VOL;
         vol_hold_reg <= PCRB_RST_VOL;
         vol_pend_reg <= 1'b0;
      end else if (vol_req_i) begin
         if (vol_blocked) begin
            vol_hold_reg <= vol_value_i;
            vol_pend_reg <= 1'b1;
         end else begin
            vol_reg      <= vol_value_i;
            vol_pend_reg <= 1'b0;
         end
      end else if (vol_pend_reg && !vol_blocked) begin
         vol_reg      <= vol_hold_reg;
         vol_pend_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // filter coefficient change
   // ---------------------------------------------------------------
   // while closed, the latest request waits; the newest overwrites it
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         coef_wr_reg        <= 1'b0;
         coef_addr_reg      <= '0;
         coef_data_reg      <= 8'h00;
         coef_addr_hold_reg <= '0;
         coef_data_hold_reg <= 8'h00;
         coef_pend_reg      <= 1'b0;
      end else begin
         coef_wr_reg <= 1'b0;
         if (coef_req_i) begin
            if (filt_open) begin
               coef_wr_reg   <= 1'b1;
               coef_addr_reg <= coef_addr_i;
               coef_data_reg <= coef_data_i;
               coef_pend_reg <= 1'b0;
            end else begin
               coef_addr_hold_reg <= coef_addr_i;
               coef_data_hold_reg <= coef_data_i;
               coef_pend_reg      <= 1'b1;
            end
         end else if (coef_pend_reg && filt_open) begin
            coef_wr_reg   <= 1'b1;
            coef_addr_reg <= coef_addr_hold_reg;
            coef_data_reg <= coef_data_hold_reg;
            coef_pend_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata_o                   = rdata_reg;
   assign reg_rvalid_o                  = rvalid_reg;
   assign page_o                        = page_reg;
   assign block_runtime_volume_change_o = proc_reg[PCRB_BIT_VOL];
   assign allow_runtime_filter_change_o = proc_reg[PCRB_BIT_FILT];
   assign diag_cfg_a_o                  = diaga_reg;
   assign diag_cfg_b_o                  = diagb_reg;
   assign diag_cfg_c_o                  = diagc_reg;
   assign diag_data_cfg_o               = ddata_reg;
   assign digital_volume_o              = vol_reg;
   assign vol_pending_o                 = vol_pend_reg;
   assign coef_wr_o                     = coef_wr_reg;
   assign coef_addr_o                   = coef_addr_reg;
   assign coef_data_o                   = coef_data_reg;
   assign coef_pending_o                = coef_pend_reg;

endmodule
`default_nettype wire

// ==== pkg/pcrb_pkg.sv ====
// pcrb_pkg: constants of the paged configuration register bank
// assumes: 8-bit register offsets, 8-bit data, one system clock
package pcrb_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int PCRB_DW      = 8;
   localparam int PCRB_AW      = 8;
   localparam int PCRB_MON_N   = 9;
   localparam int PCRB_MON_IW  = 4;
   localparam int PCRB_COEF_AW = 6;

   typedef logic [PCRB_DW-1:0] pcrb_byte_t;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam pcrb_byte_t PCRB_OFS_PAGE   = 8'h00;
   localparam pcrb_byte_t PCRB_OFS_PROC   = 8'h03;
   localparam pcrb_byte_t PCRB_OFS_LIVE3  = 8'h43;
   localparam pcrb_byte_t PCRB_OFS_DIAGA  = 8'h4e;
   localparam pcrb_byte_t PCRB_OFS_DIAGB  = 8'h4f;
   localparam pcrb_byte_t PCRB_OFS_DIAGC  = 8'h54;
   localparam pcrb_byte_t PCRB_OFS_DDATA  = 8'h55;

   // monitor pairs: mbias, out1p, out1m, out2p, out2m, temp, bias load, avdd, gp input
   localparam pcrb_byte_t PCRB_MON_HI_OFS [PCRB_MON_N] =
      '{8'h58, 8'h62, 8'h64, 8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6e, 8'h70};
   localparam pcrb_byte_t PCRB_MON_LO_OFS [PCRB_MON_N] =
      '{8'h59, 8'h63, 8'h65, 8'h67, 8'h69, 8'h6b, 8'h6d, 8'h6f, 8'h71};

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam pcrb_byte_t PCRB_RST_PAGE   = 8'h00;
   localparam pcrb_byte_t PCRB_RST_PROC   = 8'h00;
   localparam pcrb_byte_t PCRB_RST_LIVE3  = 8'h00;
   localparam pcrb_byte_t PCRB_RST_DIAGA  = 8'hba;
   localparam pcrb_byte_t PCRB_RST_DIAGB  = 8'h4b;
   localparam pcrb_byte_t PCRB_RST_DIAGC  = 8'h48;
   localparam pcrb_byte_t PCRB_RST_DDATA  = 8'h00;
   localparam pcrb_byte_t PCRB_RST_MON_HI = 8'h00;
   localparam pcrb_byte_t PCRB_RST_MON_LO [PCRB_MON_N] =
      '{8'h01, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d};
   localparam pcrb_byte_t PCRB_RST_VOL    = 8'h00;

   // ---------------------------------------------------------------
   // processing control fields
   // ---------------------------------------------------------------
   localparam int PCRB_BIT_FILT = 0;
   localparam int PCRB_BIT_VOL  = 1;
   localparam int PCRB_BIT_RO   = 4;
   localparam pcrb_byte_t PCRB_PROC_RW_MASK = 8'hef;

endpackage

// ==== pkg/pcrb_mon_if.sv ====
// pcrb_mon_if: link between the register front end and the monitor bank
// assumes: both ends on the same clock
`timescale 1ns/100ps
`default_nettype none
interface pcrb_mon_if;
   import pcrb_pkg::*;

   logic                   smp_valid;
   logic [PCRB_MON_IW-1:0] smp_idx;
   logic [15:0]            smp_data;
   logic [PCRB_MON_IW-1:0] rd_idx;
   logic                   rd_hi;
   pcrb_byte_t             rd_data;

   modport bank (input smp_valid, smp_idx, smp_data, rd_idx, rd_hi, output rd_data);
   modport ctrl (output smp_valid, smp_idx, smp_data, rd_idx, rd_hi, input rd_data);
endinterface
`default_nettype wire

// ==== rtl/pcrb_mon_bank.sv ====
// pcrb_mon_bank: monitor reading storage, high and low byte per channel
// assumes: samples and read index come from logic on sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module pcrb_mon_bank
   import pcrb_pkg::*;
(
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   pcrb_mon_if.bank  mon
);

   // ---------------------------------------------------------------
   // per channel storage
   // ---------------------------------------------------------------
   pcrb_byte_t hi_reg [PCRB_MON_N];
   pcrb_byte_t lo_reg [PCRB_MON_N];

   for (genvar g = 0; g < PCRB_MON_N; g++) begin : g_chan
      always_ff @(posedge sys_clk_i) begin
         if (!rst_b_i) begin
            hi_reg[g] <= PCRB_RST_MON_HI;
            lo_reg[g] <= PCRB_RST_MON_LO[g];
         end else if (mon.smp_valid && mon.smp_idx == PCRB_MON_IW'(g)) begin
            hi_reg[g] <= mon.smp_data[15:8];
            lo_reg[g] <= mon.smp_data[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // read selection
   // ---------------------------------------------------------------
   always_comb begin
      mon.rd_data = 8'h00;
      if (int'(mon.rd_idx) < PCRB_MON_N) begin
         mon.rd_data = mon.rd_hi ? hi_reg[mon.rd_idx] : lo_reg[mon.rd_idx];
      end
   end

endmodule
`default_nettype wire

// ==== tb/pcrb_props.sv ====
// pcrb_props: concurrent checks on the ports of pcrb_top
// assumes: bound into pcrb_top, one clock, synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module pcrb_props
   import pcrb_pkg::*;
(
   input wire logic                                 sys_clk_i,
   input wire logic                                 rst_b_i,
   input wire pcrb_pkg::pcrb_byte_t                 reg_addr_i,
   input wire pcrb_pkg::pcrb_byte_t                 reg_wdata_i,
   input wire logic                                 reg_wr_i,
   input wire logic                                 reg_rd_i,
   input wire pcrb_pkg::pcrb_byte_t                 reg_rdata_o,
   input wire logic                                 reg_rvalid_o,
   input wire pcrb_pkg::pcrb_byte_t                 page_o,
   input wire logic                                 block_runtime_volume_change_o,
   input wire logic                                 allow_runtime_filter_change_o,
   input wire pcrb_pkg::pcrb_byte_t                 diag_cfg_a_o,
   input wire pcrb_pkg::pcrb_byte_t                 diag_cfg_b_o,
   input wire pcrb_pkg::pcrb_byte_t                 diag_cfg_c_o,
   input wire logic                                 adc_powered_i,
   input wire logic                                 vol_req_i,
   input wire pcrb_pkg::pcrb_byte_t                 vol_value_i,
   input wire pcrb_pkg::pcrb_byte_t                 digital_volume_o,
   input wire logic                                 vol_pending_o,
   input wire logic                                 coef_req_i,
   input wire logic [pcrb_pkg::PCRB_COEF_AW-1:0]    coef_addr_i,
   input wire pcrb_pkg::pcrb_byte_t                 coef_data_i,
   input wire logic                                 coef_wr_o,
   input wire logic [pcrb_pkg::PCRB_COEF_AW-1:0]    coef_addr_o,
   input wire pcrb_pkg::pcrb_byte_t                 coef_data_o,
   input wire logic                                 coef_pending_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_proc_wr;
      reg_wr_i && page_o == 8'h00 && reg_addr_i == PCRB_OFS_PROC;
   endsequence
   sequence s_paged_rd;
      reg_rd_i && page_o != 8'h00 && reg_addr_i != 8'h00;
   endsequence
   sequence s_vol_held;
      vol_req_i && block_runtime_volume_change_o && adc_powered_i ##1 !adc_powered_i && !vol_req_i;
   endsequence
   a_reset_values: assert property ($rose(rst_b_i) |-> page_o == 8'h00 && diag_cfg_a_o == 8'hba
      && diag_cfg_b_o == 8'h4b && diag_cfg_c_o == 8'h48 && !allow_runtime_filter_change_o)
      else $error("reset values wrong");
   a_page_write: assert property (reg_wr_i && reg_addr_i == 8'h00 |=> page_o == $past(reg_wdata_i))
      else $error("page write lost");
   a_proc_fields: assert property (s_proc_wr |=> block_runtime_volume_change_o == $past(reg_wdata_i[1])
      && allow_runtime_filter_change_o == $past(reg_wdata_i[0]))
      else $error("proc bits wrong");
   a_paged_read: assert property (s_paged_rd |=> reg_rvalid_o && reg_rdata_o == 8'h00)
      else $error("paged read not zero");
   a_diag_read: assert property (reg_rd_i && page_o == 8'h00 && reg_addr_i == PCRB_OFS_DIAGA
      |=> reg_rvalid_o && reg_rdata_o == $past(diag_cfg_a_o))
      else $error("diag read wrong");
   a_vol_wait: assert property (vol_req_i && block_runtime_volume_change_o && adc_powered_i
      |=> vol_pending_o && $stable(digital_volume_o))
      else $error("blocked vol not held");
   a_vol_late: assert property (s_vol_held |=> digital_volume_o == $past(vol_value_i, 2) && !vol_pending_o)
      else $error("held vol not applied");
   a_vol_open: assert property (vol_req_i && !(block_runtime_volume_change_o && adc_powered_i)
      |=> digital_volume_o == $past(vol_value_i) && !vol_pending_o)
      else $error("open vol not applied");
   a_coef_apply: assert property (coef_req_i && (allow_runtime_filter_change_o || !adc_powered_i)
      |=> coef_wr_o && coef_addr_o == $past(coef_addr_i) && coef_data_o == $past(coef_data_i))
      else $error("open coef not applied");
   a_coef_hold: assert property (coef_req_i && !allow_runtime_filter_change_o && adc_powered_i
      |=> coef_pending_o && !coef_wr_o)
      else $error("closed coef not held");
endmodule
bind pcrb_top pcrb_props u_props (
   .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rvalid_o,
   .page_o, .block_runtime_volume_change_o, .allow_runtime_filter_change_o, .diag_cfg_a_o, .diag_cfg_b_o,
   .diag_cfg_c_o, .adc_powered_i, .vol_req_i, .vol_value_i, .digital_volume_o, .vol_pending_o, .coef_req_i,
   .coef_addr_i, .coef_data_i, .coef_wr_o, .coef_addr_o, .coef_data_o, .coef_pending_o
);
`default_nettype wire

// ==== tb/pcrb_host_model.sv ====
// pcrb_host_model: host on the register port, single-byte writes and reads
// assumes: strobes launched just after a rising edge of sys_clk_i
`timescale 1ns/100ps
`default_nettype none
module pcrb_host_model
   import pcrb_pkg::*;
(
   input  wire logic                         sys_clk_i,
   input  wire logic [pcrb_pkg::PCRB_DW-1:0] reg_rdata_i,
   input  wire logic                         reg_rvalid_i,
   output logic [pcrb_pkg::PCRB_AW-1:0]      reg_addr_o,
   output logic [pcrb_pkg::PCRB_DW-1:0]      reg_wdata_o,
   output logic                              reg_wr_o,
   output logic                              reg_rd_o
);
   initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = '0;
   task automatic wr_reg(input pcrb_byte_t a, input pcrb_byte_t d);
      @(posedge sys_clk_i);
      reg_wr_o    <= 1'b1;
      reg_addr_o  <= a;
      reg_wdata_o <= (a == PCRB_OFS_PROC) ? (d & 8'h03) : d;
      @(posedge sys_clk_i);
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~reg_wdata_o;
      #1;
   endtask
   task automatic rd_reg(input pcrb_byte_t a, output pcrb_byte_t d);
      @(posedge sys_clk_i);
      reg_rd_o   <= 1'b1;
      reg_addr_o <= a;
      @(posedge sys_clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rvalid_i ? reg_rdata_i : ~reg_rdata_i;
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: self-checking run of the paged register bank
// assumes: host model on the register port, datapath inputs driven here
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import pcrb_pkg::*;
   logic        sys_clk_i = 1'b0, rst_b_i = 1'b0, adc_powered_i = 1'b0, mon_valid_i = 1'b0;
   logic        vol_req_i = 1'b0, coef_req_i = 1'b0, coef_wr_o, vol_pending_o, coef_pending_o;
   logic [3:0]  mon_chan_i = 4'h0;
   logic [15:0] mon_data_i = 16'h0000;
   logic [5:0]  coef_addr_i = 6'h00;
   pcrb_byte_t  live_event_i = 8'h00, vol_value_i = 8'h00, coef_data_i = 8'h00;
   logic        reg_wr_i, reg_rd_i, reg_rvalid_o, block_runtime_volume_change_o, allow_runtime_filter_change_o;
   logic [5:0]  coef_addr_o;
   pcrb_byte_t  reg_addr_i, reg_wdata_i, reg_rdata_o, page_o, diag_cfg_a_o, diag_cfg_b_o, diag_cfg_c_o;
   pcrb_byte_t  diag_data_cfg_o, digital_volume_o, coef_data_o;
   int          n_errors = 0, checked = 0;
   pcrb_top dut (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .reg_rvalid_o, .page_o, .block_runtime_volume_change_o, .allow_runtime_filter_change_o, .diag_cfg_a_o,
      .diag_cfg_b_o, .diag_cfg_c_o, .diag_data_cfg_o, .adc_powered_i, .live_event_i, .mon_valid_i, .mon_chan_i,
      .mon_data_i, .vol_req_i, .vol_value_i, .digital_volume_o, .vol_pending_o, .coef_req_i, .coef_addr_i,
      .coef_data_i, .coef_wr_o, .coef_addr_o, .coef_data_o, .coef_pending_o);
   pcrb_host_model host (.sys_clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));
   initial forever #25 sys_clk_i = ~sys_clk_i;
   task automatic chk(input string what, input pcrb_byte_t exp, input pcrb_byte_t got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdc(input string what, input pcrb_byte_t a, input pcrb_byte_t exp);
      pcrb_byte_t d;
      host.rd_reg(a, d);
      chk(what, exp, d);
   endtask
   task automatic vol_pulse(input pcrb_byte_t v, input logic adc_during, input logic adc_after);
      @(posedge sys_clk_i);
      vol_req_i     <= 1'b1;
      vol_value_i   <= v;
      adc_powered_i <= adc_during;
      @(posedge sys_clk_i);
      vol_req_i     <= 1'b0;
      vol_value_i   <= ~v;
      adc_powered_i <= adc_after;
      #1;
   endtask
   task automatic coef_pulse(input logic [5:0] a, input pcrb_byte_t d);
      @(posedge sys_clk_i);
      coef_req_i  <= 1'b1;
      coef_addr_i <= a;
      coef_data_i <= d;
      @(posedge sys_clk_i);
      coef_req_i  <= 1'b0;
      coef_addr_i <= ~a;
      coef_data_i <= ~d;
      #1;
   endtask
   task automatic t_reset_values;
      rdc("page", PCRB_OFS_PAGE, 8'h00);
      rdc("proc", PCRB_OFS_PROC, 8'h00);
      rdc("live", PCRB_OFS_LIVE3, 8'h00);
      rdc("diag a", PCRB_OFS_DIAGA, 8'hba);
      rdc("diag b", PCRB_OFS_DIAGB, 8'h4b);
      rdc("diag c", PCRB_OFS_DIAGC, 8'h48);
      rdc("diag data", PCRB_OFS_DDATA, 8'h00);
      for (int i = 0; i < PCRB_MON_N; i++) begin
         rdc("mon hi", PCRB_MON_HI_OFS[i], 8'h00);
         rdc("mon lo", PCRB_MON_LO_OFS[i], PCRB_RST_MON_LO[i]);
      end
   endtask
   task automatic t_page;
      host.wr_reg(PCRB_OFS_PAGE, 8'hff);
      chk("page out", 8'hff, page_o);
      rdc("page rd", PCRB_OFS_PAGE, 8'hff);
      host.wr_reg(PCRB_OFS_DIAGA, 8'h11);
      rdc("paged diag", PCRB_OFS_DIAGA, 8'h00);
      host.wr_reg(PCRB_OFS_PAGE, 8'h00);
      rdc("diag kept", PCRB_OFS_DIAGA, 8'hba);
      rdc("unmapped", 8'h01, 8'h00);
      host.wr_reg(PCRB_OFS_DIAGB, 8'h5a);
      rdc("diag b wr", PCRB_OFS_DIAGB, 8'h5a);
      host.wr_reg(PCRB_OFS_DDATA, 8'h3c);
      chk("ddata out", 8'h3c, diag_data_cfg_o);
      host.wr_reg(PCRB_OFS_PAGE, 8'h01);
      chk("page one", 8'h01, page_o);
      @(posedge sys_clk_i);
      rst_b_i <= 1'b0;
      @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      #1;
      chk("page rst", 8'h00, page_o);
      chk("diag b rst", 8'h4b, diag_cfg_b_o);
      chk("ddata rst", 8'h00, diag_data_cfg_o);
   endtask
   task automatic t_proc;
      for (int v = 0; v < 4; v++) begin
         host.wr_reg(PCRB_OFS_PROC, 8'(v));
         chk("block vol", 8'(v[1]), 8'(block_runtime_volume_change_o));
         chk("allow filt", 8'(v[0]), 8'(allow_runtime_filter_change_o));
         rdc("proc rd", PCRB_OFS_PROC, 8'(v));
      end
   endtask
   task automatic t_volume;
      host.wr_reg(PCRB_OFS_PROC, 8'h02);
      vol_pulse(8'h20, 1'b1, 1'b0);
      chk("vol held", 8'h00, digital_volume_o);
      chk("vol pend", 8'h01, 8'(vol_pending_o));
      @(posedge sys_clk_i);
      #1;
      chk("vol late", 8'h20, digital_volume_o);
      chk("vol pend off", 8'h00, 8'(vol_pending_o));
      host.wr_reg(PCRB_OFS_PROC, 8'h00);
      vol_pulse(8'h31, 1'b1, 1'b1);
      chk("vol open", 8'h31, digital_volume_o);
   endtask
   task automatic t_coef;
      coef_pulse(6'h2a, 8'h5c);
      chk("coef pend", 8'h01, 8'(coef_pending_o));
      chk("coef early", 8'h00, 8'(coef_wr_o));
      host.wr_reg(PCRB_OFS_PROC, 8'h01);
      @(posedge sys_clk_i);
      #1;
      chk("coef wr", 8'h01, 8'(coef_wr_o));
      chk("coef addr", 8'h2a, 8'(coef_addr_o));
      chk("coef data", 8'h5c, coef_data_o);
      coef_pulse(6'h15, 8'ha3);
      chk("coef direct", 8'h01, 8'(coef_wr_o));
      chk("coef data2", 8'ha3, coef_data_o);
      host.wr_reg(PCRB_OFS_PROC, 8'h00);
      @(posedge sys_clk_i) adc_powered_i <= 1'b0;
      coef_pulse(6'h07, 8'h4d);
      chk("coef adc off", 8'h4d, coef_data_o);
   endtask
   task automatic t_monitor;
      @(posedge sys_clk_i);
      mon_valid_i  <= 1'b1;
      mon_chan_i   <= 4'h5;
      mon_data_i   <= 16'h1234;
      live_event_i <= 8'ha5;
      @(posedge sys_clk_i);
      mon_chan_i   <= 4'h9;
      mon_data_i   <= 16'hbeef;
      @(posedge sys_clk_i);
      mon_valid_i  <= 1'b0;
      rdc("temp hi", PCRB_MON_HI_OFS[5], 8'h12);
      rdc("temp lo", PCRB_MON_LO_OFS[5], 8'h34);
      rdc("gp lo", PCRB_MON_LO_OFS[8], 8'h0d);
      rdc("live rd", PCRB_OFS_LIVE3, 8'ha5);
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      t_reset_values();
      t_page();
      t_proc();
      t_volume();
      t_coef();
      t_monitor();
      tally_and_finish();
   end
   initial begin
      repeat (4000) @(posedge sys_clk_i);
      n_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
